// ### pkg/shlk_pkg.sv
// Purpose: Constants and types for the shared lock semaphore
// Assumes: One clock, asynchronous active-high reset
// Notes: Operation list below
// Operation
// - Lock is one 32-bit word read and updated by both environments.
// - Bit 0 is the pending flag.
// - Bit 1 is the owned flag.
// - Bits 31:2 are reserved; acquire and release never change them.
// - Acquire clears pending and sets owned; if already owned, sets pending.
// - Acquire answers all-ones when granted, zero when only pending recorded.
// - Word-port writes are compare-exchange against the staged compare value; acquire and release ports update atomically in one read.
// - Release clears owned and pending with mask 03h, returns old pending.
// - Lock-free signal is a release bit that interrupts the other side.
// - Release signal only when pending was set.

package shlk_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SHLK_OFS_WORD = 8'h00;
  localparam logic [7:0] SHLK_OFS_ACQ_OS = 8'h04;
  localparam logic [7:0] SHLK_OFS_ACQ_FW = 8'h08;
  localparam logic [7:0] SHLK_OFS_REL_OS = 8'h0C;
  localparam logic [7:0] SHLK_OFS_REL_FW = 8'h10;
  localparam logic [7:0] SHLK_OFS_STATUS = 8'h14;
  localparam logic [7:0] SHLK_OFS_MASK = 8'h18;
  localparam logic [7:0] SHLK_OFS_SIGNAL = 8'h1C;
  localparam logic [7:0] SHLK_OFS_CMPX = 8'h20;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int SHLK_BIT_PEND = 0;
  localparam int SHLK_BIT_OWN = 1;
  localparam logic [31:0] SHLK_REL_MASK = 32'h0000_0003;
  localparam logic [31:0] SHLK_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] SHLK_GRANT = 32'hFFFF_FFFF;
  localparam logic [31:0] SHLK_REFUSE = 32'h0000_0000;
  localparam logic [1:0] SHLK_IRQ_RST = 2'h0;
  // Status bits: 0 = os_side_release_signal, 1 = firmware_side_release_signal
  localparam int SHLK_BIT_OS_RLS = 0;
  localparam int SHLK_BIT_FW_RLS = 1;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } shlk_req_t;

  typedef enum logic [1:0] {
    SHLK_OP_ACQ = 2'b00,
    SHLK_OP_REL = 2'b01,
    SHLK_OP_CMPX = 2'b10
  } shlk_op_t;

endpackage : shlk_pkg

// ### src/shlk_update.sv
// Purpose: Computes the new lock word for one atomic operation
// Assumes: Purely combinational
// Notes: Shared by acquire, release and compare-exchange paths
`timescale 1ns/1ps
`default_nettype none

module shlk_update (
  input wire shlk_pkg::shlk_op_t op, // Operation kind
  input wire logic [31:0] cur, // Word as read
  input wire logic [31:0] cmp_val, // Expected value for compare-exchange
  input wire logic [31:0] new_val, // Replacement for compare-exchange
  output logic [31:0] nxt_word, // Word after the operation
  output logic [31:0] result // Answer to the requester
);

  wire logic owned = cur[shlk_pkg::SHLK_BIT_OWN];
  wire logic match = (cur == cmp_val);
  logic [31:0] acq_word;

  always_comb begin
    acq_word = cur;
    acq_word[shlk_pkg::SHLK_BIT_PEND] = owned;
    acq_word[shlk_pkg::SHLK_BIT_OWN] = 1'b1;
    nxt_word = cur;
    result = shlk_pkg::SHLK_REFUSE;
    unique case (op)
      shlk_pkg::SHLK_OP_ACQ: begin
        nxt_word = acq_word;
        result = owned ? shlk_pkg::SHLK_REFUSE : shlk_pkg::SHLK_GRANT;
      end
      shlk_pkg::SHLK_OP_REL: begin
        nxt_word = cur & ~shlk_pkg::SHLK_REL_MASK;
        result = {31'h0000_0000, cur[shlk_pkg::SHLK_BIT_PEND]};
      end
      shlk_pkg::SHLK_OP_CMPX: begin
        nxt_word = match ? new_val : cur;
        result = cur;
      end
      default: begin
        nxt_word = cur;
        result = shlk_pkg::SHLK_REFUSE;
      end
    endcase
  end

endmodule : shlk_update

`default_nettype wire

// ### src/shlk_top.sv
// Purpose: Two-party hardware semaphore with release interrupts
// Assumes: Register port with one-cycle read latency; one port serialises all parties
// Notes: Each access is atomic since the word updates in a single cycle
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module shlk_top (
  input wire logic clock, // 200 MHz clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after read strobe
  output logic os_irq, // Interrupt to OS side
  output logic fw_irq, // Interrupt to firmware side
  output logic irq // Combined masked interrupt
);

  // ****************************************
  // Decode
  // ****************************************
  shlk_pkg::shlk_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  logic [31:0] word_ff, nxt_word;
  logic [31:0] cmp_ff, nxt_cmp;
  logic [1:0] status_ff, nxt_status;
  logic [1:0] mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;

  wire logic rd_word = req.rd && req.addr == shlk_pkg::SHLK_OFS_WORD;
  wire logic rd_acq_os = req.rd && req.addr == shlk_pkg::SHLK_OFS_ACQ_OS;
  wire logic rd_acq_fw = req.rd && req.addr == shlk_pkg::SHLK_OFS_ACQ_FW;
  wire logic rd_rel_os = req.rd && req.addr == shlk_pkg::SHLK_OFS_REL_OS;
  wire logic rd_rel_fw = req.rd && req.addr == shlk_pkg::SHLK_OFS_REL_FW;
  wire logic rd_stat = req.rd && req.addr == shlk_pkg::SHLK_OFS_STATUS;
  wire logic rd_mask = req.rd && req.addr == shlk_pkg::SHLK_OFS_MASK;
  wire logic rd_cmpv = req.rd && req.addr == shlk_pkg::SHLK_OFS_CMPX;
  wire logic wr_word = req.wr && req.addr == shlk_pkg::SHLK_OFS_WORD;
  wire logic wr_stat = req.wr && req.addr == shlk_pkg::SHLK_OFS_STATUS;
  wire logic wr_mask = req.wr && req.addr == shlk_pkg::SHLK_OFS_MASK;
  wire logic wr_sig = req.wr && req.addr == shlk_pkg::SHLK_OFS_SIGNAL;
  wire logic wr_cmpv = req.wr && req.addr == shlk_pkg::SHLK_OFS_CMPX;

  wire logic do_acq = rd_acq_os | rd_acq_fw;
  wire logic do_rel = rd_rel_os | rd_rel_fw;
  wire logic is_fw = rd_acq_fw | rd_rel_fw;

  // Reads of an acquire or release port perform the whole atomic operation
  wire shlk_pkg::shlk_op_t op = do_acq ? shlk_pkg::SHLK_OP_ACQ :
                                do_rel ? shlk_pkg::SHLK_OP_REL : shlk_pkg::SHLK_OP_CMPX;

  logic [31:0] upd_word;
  logic [31:0] upd_result;

  shlk_update u_update (
    .op(op),
    .cur(word_ff),
    .cmp_val(cmp_ff),
    .new_val(req.wdata),
    .nxt_word(upd_word),
    .result(upd_result)
  );

  // ****************************************
  // Lock word
  // ****************************************
  // Writing the word port is a compare-exchange against the staged compare value
  assign nxt_word = (do_acq | do_rel | wr_word) ? upd_word : word_ff;
  assign nxt_cmp = wr_cmpv ? req.wdata : cmp_ff;

  // ****************************************
  // Release events
  // ****************************************
  // A release that found pending set raises the bit for the other side
  wire logic rel_pend = do_rel & word_ff[shlk_pkg::SHLK_BIT_PEND];
  wire logic [1:0] hw_set = {rel_pend & ~is_fw, rel_pend & is_fw}
                          | (wr_sig ? req.wdata[1:0] : 2'h0);
  wire logic [1:0] sw_clr = wr_stat ? req.wdata[1:0] : 2'h0;
  // Set wins over a clear in the same cycle
  assign nxt_status = (status_ff & ~sw_clr) | hw_set;
  assign nxt_mask = wr_mask ? req.wdata[1:0] : mask_ff;

  // ****************************************
  // Read data
  // ****************************************
  assign nxt_rdata = rd_word ? word_ff :
                     (do_acq | do_rel) ? upd_result :
                     rd_stat ? {30'h0000_0000, status_ff} :
                     rd_mask ? {30'h0000_0000, mask_ff} :
                     rd_cmpv ? cmp_ff : 32'h0000_0000;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      word_ff <= shlk_pkg::SHLK_WORD_RST;
      cmp_ff <= shlk_pkg::SHLK_WORD_RST;
      status_ff <= shlk_pkg::SHLK_IRQ_RST;
      mask_ff <= shlk_pkg::SHLK_IRQ_RST;
      rdata_ff <= shlk_pkg::SHLK_WORD_RST;
    end else begin
      word_ff <= nxt_word;
      cmp_ff <= nxt_cmp;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  // Status bit 0 wakes the OS side (fw released), bit 1 wakes firmware (OS released)
  assign os_irq = status_ff[shlk_pkg::SHLK_BIT_OS_RLS] & mask_ff[shlk_pkg::SHLK_BIT_OS_RLS];
  assign fw_irq = status_ff[shlk_pkg::SHLK_BIT_FW_RLS] & mask_ff[shlk_pkg::SHLK_BIT_FW_RLS];
  assign irq = os_irq | fw_irq;

endmodule : shlk_top

`default_nettype wire

// ### tb/shlk_properties.sv
// Purpose: Port properties of the shared lock
// Assumes: One clock domain
// Notes: Bound to shlk_top
`timescale 1ns/1ps
`default_nettype none
module shlk_properties (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic [7:0] addr, // Address
  input wire logic rd_en, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic os_irq, // OS interrupt
  input wire logic fw_irq, // Firmware interrupt
  input wire logic irq // Joined interrupt
);
  wire acq = rd_en && (addr == shlk_pkg::SHLK_OFS_ACQ_OS || addr == shlk_pkg::SHLK_OFS_ACQ_FW);
  wire rel_os = rd_en && addr == shlk_pkg::SHLK_OFS_REL_OS;
  wire rel = rel_os || (rd_en && addr == shlk_pkg::SHLK_OFS_REL_FW);
  wire stat_rd = rd_en && addr == shlk_pkg::SHLK_OFS_STATUS;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_two_acq; acq ##1 acq; endsequence
  sequence s_rel_acq; rel ##1 acq; endsequence
  sequence s_rel_stat; rel_os ##1 (rdata[0] && stat_rd); endsequence
  sequence s_ref_rel; acq ##1 (rdata == 32'h0000_0000 && rel); endsequence
  chk_irq_join: assert property (irq == (os_irq || fw_irq)) else $error("bad irq");
  chk_idle_zero: assert property (!rd_en |=> rdata == 32'h0000_0000) else $error("bad idle");
  chk_acq_answer: assert property (acq |=> rdata == 32'hFFFF_FFFF || rdata == 32'h0000_0000)
    else $error("bad acq");
  chk_acq_twice: assert property (s_two_acq |=> rdata == 32'h0000_0000) else $error("bad twice");
  chk_rel_answer: assert property (rel |=> rdata[31:1] == 31'h0000_0000) else $error("bad rel");
  chk_rel_frees: assert property (s_rel_acq |=> rdata == 32'hFFFF_FFFF) else $error("bad free");
  chk_rel_quiet: assert property (rel ##1 !rdata[0] |-> !$rose(irq)) else $error("bad quiet");
  chk_rel_status: assert property (s_rel_stat |=> rdata[1]) else $error("bad status");
  chk_pend_return: assert property (s_ref_rel |=> rdata[0]) else $error("bad pend");
endmodule : shlk_properties
bind shlk_top shlk_properties u_chk (.clock(clock), .reset(reset), .addr(addr), .rd_en(rd_en),
  .rdata(rdata), .os_irq(os_irq), .fw_irq(fw_irq), .irq(irq));
`default_nettype wire

// ### tb/shlk_party.sv
// Purpose: Software parties waking on release
// Assumes: Level interrupts
// Notes: Wake flag is sticky
`timescale 1ns/1ps
`default_nettype none
module shlk_party (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic os_irq, // OS interrupt
  input wire logic fw_irq, // Firmware interrupt
  output logic fw_wake_ff // Woke on either the firmware or the OS interrupt
);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) fw_wake_ff <= 1'b0;
    else fw_wake_ff <= fw_wake_ff | fw_irq | os_irq;
  end
endmodule : shlk_party
`default_nettype wire

// ### tb/tb_shlk_top.sv
// Purpose: Self-checking bench for shlk_top
// Assumes: Model mirrors lock, status, mask
// Notes: Random traffic after directed steps
`timescale 1ns/1ps
`default_nettype none
module tb_shlk_top;
  logic clock = 0, reset = 1, wr_en = 0, rd_en = 0, os_irq, fw_irq, irq, wake;
  logic [7:0] addr = 8'h00, rq[$] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h14, 8'h08, 8'h10, 8'h04};
  logic [7:0] wa[6] = '{8'h00, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
  logic [31:0] wdata = 0, rdata, word = 0, cmpv = 0, e, r;
  logic [1:0] stat = 0, mask = 0;
  int n_errors = 0, cmp_count = 0, seed = 56;
  always #2.5 clock = ~clock;
  shlk_top uut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .os_irq(os_irq), .fw_irq(fw_irq), .irq(irq));
  shlk_party u_party (.clock(clock), .reset(reset), .os_irq(os_irq), .fw_irq(fw_irq), .fw_wake_ff(wake));
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, s, x);
    end
  endtask : check
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    e = 0;
    if (w) case (a)
      8'h00: if (word === cmpv) word = d;
      8'h14: stat = stat & ~d[1:0];
      8'h18: mask = d[1:0];
      8'h1C: stat = stat | d[1:0];
      8'h20: cmpv = d;
    endcase else case (a)
      8'h00: e = word;
      8'h04, 8'h08: begin
        e = word[1] ? 0 : 32'hFFFF_FFFF;
        word[1:0] = {1'b1, word[1]};
      end
      8'h0C, 8'h10: begin
        e = {31'h0, word[0]};
        stat[a == 8'h0C] |= word[0];
        word[1:0] = 2'b00;
      end
      8'h14: e = {30'h0, stat};
      8'h18: e = {30'h0, mask};
      8'h20: e = cmpv;
    endcase
    @(posedge clock);
    #1;
    if (!w) check(rdata, e);
    check({irq, fw_irq, os_irq}, {|(stat & mask), stat[1] & mask[1], stat[0] & mask[0]});
  endtask : acc
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 0;
    #1;
    check(rdata, 0);
    acc(8'h18, 1, 3);
    foreach (rq[i]) acc(rq[i], 0, 0);
    check({31'h0, wake}, 1);
    acc(8'h0C, 0, 0);
    acc(8'h20, 1, 0);
    acc(8'h00, 1, 32'hA5A5_0000);
    acc(8'h04, 0, 0);
    acc(8'h00, 1, 32'hFFFF_FFFF);
    acc(8'h00, 0, 0);
    repeat (400) begin
      r = $random(seed);
      if (r[0]) acc(wa[r[3:1] % 6], 1, $random(seed));
      else acc(8'h00 + 8'(r[7:4] % 9) * 4 + (r[7:4] % 9 == 8 ? 8'h1C : 0), 0, 0);
    end
    rd_en <= 0;
    wr_en <= 0;
    @(posedge clock);
    stop_test();
  end
endmodule : tb_shlk_top
`default_nettype wire
